/* design/ats_pkg.sv */
// constants shared by the address table binary search unit
package ats_pkg;

  // ----------------------------------------------------------------
  // table geometry
  // ----------------------------------------------------------------
  localparam int TBL_ADDR_W = 13;
  localparam int TBL_DEPTH = 8192;
  localparam int TBL_BANKS = 6;
  localparam int ARG_W = 48;
  localparam int WORD_W = 16;
  localparam int NIB_N = 12;

  // ----------------------------------------------------------------
  // decoded lookup-unit select codes {sel2, sel1, sel0}
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_ARG_LO = 3'h1;
  localparam logic [2:0] SEL_ARG_MID = 3'h2;
  localparam logic [2:0] SEL_ARG_HI = 3'h3;
  localparam logic [2:0] SEL_TBL_LO = 3'h4;
  localparam logic [2:0] SEL_TBL_MID = 3'h5;
  localparam logic [2:0] SEL_TBL_HI = 3'h6;
  localparam logic [2:0] SEL_OUTCOME = 3'h7;

  // ----------------------------------------------------------------
  // search_outcome fields
  // ----------------------------------------------------------------
  localparam int OUT_MATCH_BIT = 15;
  localparam int OUT_UNUSED_BIT = 14;
  localparam int OUT_ADDR_MSB = 13;
  localparam int OUT_ADDR_LSB = 1;
  localparam int OUT_ABOVE_BIT = 0;
  localparam logic [15:0] OUTCOME_RST = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEER_CLK_NS = 100;
  localparam int STEER_TICK_CYC = STEER_CLK_NS / CLK_PERIOD_NS;
  localparam int START_DELAY_NS = 50;
  localparam int START_DELAY_CYC =
    (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ATS_IDLE  = 3'b000,
    ATS_DELAY = 3'b001,
    ATS_STEER = 3'b011,
    ATS_FETCH = 3'b010,
    ATS_CMP   = 3'b110
  } ats_state_t;

endpackage

/* design/ats_cmp_if.sv */
// link between the search controller and one nibble comparator
`timescale 1ns/10ps
interface ats_cmp_if;
  logic load;
  logic [3:0] bus_nib;
  logic [3:0] tbl_nib;
  logic [3:0] arg_nib;
  logic gt;
  logic eq;
  modport ctl (output load, output bus_nib, output tbl_nib,
               input arg_nib, input gt, input eq);
  modport cmp (input load, input bus_nib, input tbl_nib,
               output arg_nib, output gt, output eq);
endinterface

/* design/ats_nib_cmp.sv */
// one nibble comparator element with its argument latch
`timescale 1ns/10ps
module ats_nib_cmp
  import ats_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  ats_cmp_if.cmp link
);

  logic [3:0] arg_ff;

  // ----------------------------------------------------------------
  // argument latch
  // ----------------------------------------------------------------
  // latch nibble
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      arg_ff <= 4'h0;
    end else if (link.load) begin
      arg_ff <= link.bus_nib;
    end
  end

  assign link.arg_nib = arg_ff;
  assign link.gt = arg_ff > link.tbl_nib;
  assign link.eq = arg_ff == link.tbl_nib;

  nib_excl_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !(link.gt && link.eq) && (link.eq == (arg_ff == link.tbl_nib)))
    else $error("nibble compare gives greater and equal together");

endmodule

/* design/ats_search_top.sv */
// address table binary search unit: table, comparators, controller
`timescale 1ns/10ps

// Notes on behaviour
// - table address comes from cpu lines or probe lines via 2:1 select.
// - steering follows done and changes only on the 100 ns tick.
// - 48-bit compare is built from low, middle and high 16-bit slices.
// - table holds 8K entries of 48 bits, one entry per location.
// - table is six byte-wide 8K banks, one addresser at a time.
// - transceiver joins cpu data to compare bus, both directions.
// - transceiver direction from cpu write line and three selects.
// - each element latches one argument nibble and compares per probe.
// - comparator latches also hold words for moves and maintenance.
// - after high word and start delay, start probe address is captured as first probe.
// - dropping done blocks cpu access and selects probe addressing.
// - after greater or less the next probe address is driven.
// - equal ends search, raises done, returns cpu access.
// - last probe status and location latched as search_outcome.
// - search_outcome readable only while no search runs.
// - bit 15 is the match flag.
// - bits 13:1 last probe location, bit 14 unused.
// - bit 0 above flag, set only on no match with argument larger.
// - table contents readable by compare, maintenance and management.
// - probing an odd bottom leaf without match also ends search.
module ats_search_top
  import ats_pkg::*;
#(
  parameter int ADDR_W = TBL_ADDR_W,
  parameter int DEPTH = TBL_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] cpu_table_addr_in,
  input wire logic [ADDR_W-1:0] start_probe_addr_in,
  input wire logic cpu_write_line_in,
  input wire logic lookup_select_0_in,
  input wire logic lookup_select_1_in,
  input wire logic lookup_select_2_in,
  input wire logic [WORD_W-1:0] cpu_data_bus_in,
  output logic [WORD_W-1:0] cpu_data_bus_out,
  output logic cpu_data_bus_oe_out,
  output logic search_done_out,
  output logic table_addr_steer_out,
  output logic [ADDR_W-1:0] probe_addr_bus_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ats_state_t state_ff;
  logic done_ff;
  logic steer_ff;
  logic [ADDR_W-1:0] probe_ff;
  logic [ADDR_W-1:0] step_ff;
  logic [3:0] tick_cnt_ff;
  logic [3:0] delay_cnt_ff;
  logic [WORD_W-1:0] outcome_ff;
  logic [ARG_W-1:0] rd_word_ff;
  logic [WORD_W-1:0] data_out_ff;
  logic data_oe_ff;

  logic [2:0] sel;
  logic grant;
  logic cpu_wr;
  logic cpu_rd;
  logic [ADDR_W-1:0] tbl_addr;
  logic [ARG_W-1:0] tbl_word;
  logic [ARG_W-1:0] arg_word;
  logic [NIB_N-1:0] nib_gt;
  logic [NIB_N-1:0] nib_eq;
  logic cmp_gt;
  logic cmp_eq;
  logic [ADDR_W-1:0] start_low;
  logic steer_tick;

  // the table itself: six byte banks sharing one address
  logic [7:0] tbl_bank [TBL_BANKS][DEPTH];

  // ----------------------------------------------------------------
  // decoder and access grant
  // ----------------------------------------------------------------
  assign sel = {lookup_select_2_in, lookup_select_1_in,
                lookup_select_0_in};
  // no cpu access while done is low
  // grant also waits for the selector to come back
  assign grant = done_ff && !steer_ff && (state_ff == ATS_IDLE);
  assign cpu_wr = grant && cpu_write_line_in && (sel != SEL_NONE);
  assign cpu_rd = grant && !cpu_write_line_in && (sel != SEL_NONE);

  // ----------------------------------------------------------------
  // address selector and table
  // ----------------------------------------------------------------
  // 2:1 address select
  assign tbl_addr = steer_ff ? probe_ff : cpu_table_addr_in;

  // one location delivers the whole 48-bit entry
  // entry spread over six byte banks
  always_comb begin
    tbl_word = '0;
    for (int b = 0; b < TBL_BANKS; b++) begin
      tbl_word[b*8 +: 8] = tbl_bank[b][tbl_addr];
    end
  end

  // maintenance store copies the latched argument into the entry;
  // only reachable on cpu addressing, so probes never write
  // latches serve as the staging store for table updates
  always_ff @(posedge clk_in) begin
    if (cpu_wr && (sel == SEL_TBL_LO)) begin
      for (int b = 0; b < TBL_BANKS; b++) begin
        tbl_bank[b][tbl_addr] <= arg_word[b*8 +: 8];
      end
    end
  end

  // held while the cpu addresses: cpu-addressed entries never reach compare
  // table data read for comparison
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_word_ff <= '0;
    end else if (steer_ff) begin
      rd_word_ff <= tbl_word;
    end
  end

  // ----------------------------------------------------------------
  // nibble comparators
  // ----------------------------------------------------------------
  ats_cmp_if cif [NIB_N] ();

  // three 16-bit slices of four nibbles each
  for (genvar i = 0; i < NIB_N; i++) begin : g_nib
    // write data flows from cpu bus onto the compare bus
    assign cif[i].load = cpu_wr && (((i / 4) == 0 && sel == SEL_ARG_LO)
      || ((i / 4) == 1 && sel == SEL_ARG_MID)
      || ((i / 4) == 2 && (sel == SEL_ARG_HI || sel == SEL_OUTCOME)));
    assign cif[i].bus_nib = cpu_data_bus_in[(i % 4)*4 +: 4];
    assign cif[i].tbl_nib = rd_word_ff[i*4 +: 4];
    assign arg_word[i*4 +: 4] = cif[i].arg_nib;
    assign nib_gt[i] = cif[i].gt;
    assign nib_eq[i] = cif[i].eq;
    ats_nib_cmp u_cmp (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .link(cif[i])
    );
  end

  // most significant differing nibble decides the magnitude
  // slices combined high to low
  always_comb begin
    logic decided;
    decided = 1'b0;
    cmp_gt = 1'b0;
    for (int i = NIB_N - 1; i >= 0; i--) begin
      if (!decided && !nib_eq[i]) begin
        decided = 1'b1;
        cmp_gt = nib_gt[i];
      end
    end
    cmp_eq = !decided;
  end

  // ----------------------------------------------------------------
  // 100 ns steering tick
  // ----------------------------------------------------------------
  assign steer_tick = (tick_cnt_ff == 4'(STEER_TICK_CYC - 1));

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt_ff <= 4'h0;
    end else if (steer_tick) begin
      tick_cnt_ff <= 4'h0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 4'h1;
    end
  end

  // steering follows done, gated by the slow tick
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      steer_ff <= 1'b0;
    end else if (steer_tick) begin
      steer_ff <= !done_ff;
    end
  end

  // ----------------------------------------------------------------
  // search controller
  // ----------------------------------------------------------------
  // first step is half the start address's lowest set bit, so the
  // start location fixes the tree depth; odd starts are leaves
  assign start_low = start_probe_addr_in & (~start_probe_addr_in
                     + {{(ADDR_W-1){1'b0}}, 1'b1});

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= ATS_IDLE;
      delay_cnt_ff <= 4'h0;
    end else begin
      case (state_ff)
        ATS_IDLE: begin
          // high word is the last write and arms the search
          if (cpu_wr && sel == SEL_ARG_HI) begin
            state_ff <= ATS_DELAY;
            delay_cnt_ff <= 4'h0;
          end
        end
        ATS_DELAY: begin
          delay_cnt_ff <= delay_cnt_ff + 4'h1;
          if (delay_cnt_ff == 4'(START_DELAY_CYC - 1)) begin
            state_ff <= ATS_STEER;
          end
        end
        ATS_STEER: begin
          if (steer_ff) begin
            state_ff <= ATS_FETCH;
          end
        end
        ATS_FETCH: begin
          state_ff <= ATS_CMP;
        end
        ATS_CMP: begin
          // leaf reached without match ends the search
          if (cmp_eq || step_ff == '0) begin
            state_ff <= ATS_IDLE;
          end else begin
            state_ff <= ATS_FETCH;
          end
        end
        default: begin
          state_ff <= ATS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_ff <= 1'b1;
    end else if (state_ff == ATS_DELAY &&
                 delay_cnt_ff == 4'(START_DELAY_CYC - 1)) begin
      // drop done to start the search
      done_ff <= 1'b0;
    end else if (state_ff == ATS_CMP && (cmp_eq || step_ff == '0)) begin
      done_ff <= 1'b1;
    end
  end

  // probe address and step
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      probe_ff <= '0;
      step_ff <= '0;
    end else if (state_ff == ATS_DELAY &&
                 delay_cnt_ff == 4'(START_DELAY_CYC - 1)) begin
      // capture start location as first probe and base
      // cpu holds it valid through the delay window
      probe_ff <= start_probe_addr_in;
      step_ff <= start_low >> 1;
    end else if (state_ff == ATS_CMP && !cmp_eq && step_ff != '0) begin
      // greater moves up, less moves down
      probe_ff <= cmp_gt ? probe_ff + step_ff : probe_ff - step_ff;
      step_ff <= step_ff >> 1;
    end
  end

  // outcome latched at the last probe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      outcome_ff <= OUTCOME_RST;
    end else if (state_ff == ATS_CMP && (cmp_eq || step_ff == '0)) begin
      outcome_ff[OUT_MATCH_BIT] <= cmp_eq;
      // last probe location, bit 14 stays clear
      outcome_ff[OUT_UNUSED_BIT] <= 1'b0;
      outcome_ff[OUT_ADDR_MSB:OUT_ADDR_LSB] <= probe_ff;
      outcome_ff[OUT_ABOVE_BIT] <= !cmp_eq && cmp_gt;
    end
  end

  // ----------------------------------------------------------------
  // cpu read path through the transceiver
  // ----------------------------------------------------------------
  // drive toward the cpu only on a granted read select
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_oe_ff <= 1'b0;
    end else begin
      data_oe_ff <= cpu_rd;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_out_ff <= 16'h0000;
    end else if (!cpu_rd) begin
      data_out_ff <= 16'h0000;
    end else if (sel == SEL_ARG_LO) begin
      // latch contents read back for moves
      data_out_ff <= arg_word[15:0];
    end else if (sel == SEL_ARG_MID) begin
      data_out_ff <= arg_word[31:16];
    end else if (sel == SEL_ARG_HI) begin
      data_out_ff <= arg_word[47:32];
    end else if (sel == SEL_TBL_LO) begin
      // reverse direction lets management read the table
      // table contents visible to maintenance software
      data_out_ff <= tbl_word[15:0];
    end else if (sel == SEL_TBL_MID) begin
      data_out_ff <= tbl_word[31:16];
    end else if (sel == SEL_TBL_HI) begin
      data_out_ff <= tbl_word[47:32];
    end else begin
      // outcome only reached through the granted decoder
      data_out_ff <= outcome_ff;
    end
  end

  assign cpu_data_bus_out = data_out_ff;
  assign cpu_data_bus_oe_out = data_oe_ff;
  assign search_done_out = done_ff;
  assign table_addr_steer_out = steer_ff;
  assign probe_addr_bus_out = probe_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  steer_on_tick_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $changed(steer_ff) |-> $past(steer_tick) && (steer_ff != $past(done_ff)))
    else $error("selector changed off the tick or against done");

  probe_selects_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    state_ff == ATS_FETCH |-> steer_ff && tbl_addr == probe_ff)
    else $error("probe issued without probe addressing");

  start_capture_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $fell(done_ff) |-> probe_ff == $past(start_probe_addr_in))
    else $error("first probe is not the presented start location");

  block_during_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !done_ff && !$past(done_ff) |-> !cpu_data_bus_oe_out)
    else $error("cpu data driven while a search runs");

  search_bound_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $fell(done_ff) |-> ##[1:60] done_ff)
    else $error("search did not finish in time");

  match_end_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    state_ff == ATS_CMP && cmp_eq |=> done_ff && outcome_ff[OUT_MATCH_BIT]
      && outcome_ff[OUT_ADDR_MSB:OUT_ADDR_LSB] == $past(probe_ff))
    else $error("match did not end the search with its location");

  flags_excl_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !(outcome_ff[OUT_MATCH_BIT] && outcome_ff[OUT_ABOVE_BIT])
      && !outcome_ff[OUT_UNUSED_BIT])
    else $error("match and above flags set together");

  next_probe_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    state_ff == ATS_CMP && !cmp_eq && step_ff != '0 && cmp_gt
      |=> probe_ff == $past(probe_ff) + $past(step_ff))
    else $error("greater result did not move the probe up");

  done_delay_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    state_ff == ATS_IDLE && cpu_wr && sel == SEL_ARG_HI
      |-> done_ff [*6] ##1 !done_ff)
    else $error("done did not drop after the start delay");

endmodule

/* dv/ats_cpu_model.sv */
// bridge processor model driving the lookup unit's cpu side
`timescale 1ns/10ps
module ats_cpu_model
  import ats_pkg::*;
(
  input wire logic clk_in,
  input wire logic [WORD_W-1:0] rd_data_in,
  input wire logic rd_oe_in,
  input wire logic search_done_in,
  output logic [TBL_ADDR_W-1:0] cpu_table_addr_out,
  output logic [TBL_ADDR_W-1:0] start_probe_addr_out,
  output logic cpu_write_line_out,
  output logic [2:0] lookup_select_out,
  output logic [WORD_W-1:0] cpu_data_bus_out
);
  initial begin
    cpu_table_addr_out = 13'h0000;
    start_probe_addr_out = 13'h0000;
    cpu_write_line_out = 1'b0;
    lookup_select_out = SEL_NONE;
    cpu_data_bus_out = 16'h0000;
  end

  // one cycle on the cpu bus; a read holds select over two edges
  task automatic access(input logic [2:0] code, input logic wr,
                        input logic [12:0] loc, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic oe);
    @(posedge clk_in);
    #1;
    lookup_select_out = code;
    cpu_write_line_out = wr;
    cpu_table_addr_out = loc;
    cpu_data_bus_out = wdata;
    @(posedge clk_in);
    if (!wr) begin
      @(posedge clk_in);
    end
    #1;
    rdata = rd_data_in;
    oe = rd_oe_in;
    // released lines must not keep their last value
    lookup_select_out = SEL_NONE;
    cpu_data_bus_out = ~wdata;
    cpu_table_addr_out = ~loc;
  endtask

  task automatic wr(input logic [2:0] code, input logic [12:0] loc,
                    input logic [15:0] wdata);
    logic [15:0] d;
    logic o;
    access(code, 1'b1, loc, wdata, d, o);
  endtask

  // caller stores entries in ascending location order
  // sorted table
  task automatic store(input logic [12:0] loc, input logic [47:0] val);
    wr(SEL_ARG_LO, 13'h0000, val[15:0]);
    wr(SEL_ARG_MID, 13'h0000, val[31:16]);
    wr(SEL_OUTCOME, 13'h0000, val[47:32]);
    wr(SEL_TBL_LO, loc, val[15:0]);
  endtask

  task automatic search(input logic [47:0] arg, input logic [12:0] start);
    start_probe_addr_out = start;
    wr(SEL_ARG_LO, 13'h0000, arg[15:0]);
    wr(SEL_ARG_MID, 13'h0000, arg[31:16]);
    wr(SEL_ARG_HI, 13'h0000, arg[47:32]);
    // start held until the controller takes it
    repeat (20) begin
      @(posedge clk_in);
      #1;
      if (!search_done_in) break;
    end
    start_probe_addr_out = ~start;
  endtask
endmodule

/* dv/ats_search_top_tb_top.sv */
// self-checking bench for the address table binary search unit
`timescale 1ns/10ps
module ats_search_top_tb_top;
  import ats_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [12:0] addr, start;
  logic wr_ln;
  logic [2:0] sel;
  logic [15:0] din, dout;
  logic oe, done, steer;
  logic [12:0] probe;
  int err_total = 0;
  int cmp_count = 0;

  always #5 clk_in = ~clk_in;

  ats_search_top ats_search_top_i (
    .clk_in(clk_in), .rst_in(rst_in), .cpu_table_addr_in(addr),
    .start_probe_addr_in(start), .cpu_write_line_in(wr_ln),
    .lookup_select_0_in(sel[0]), .lookup_select_1_in(sel[1]),
    .lookup_select_2_in(sel[2]), .cpu_data_bus_in(din),
    .cpu_data_bus_out(dout), .cpu_data_bus_oe_out(oe),
    .search_done_out(done), .table_addr_steer_out(steer),
    .probe_addr_bus_out(probe));

  ats_cpu_model ats_cpu_model_i (
    .clk_in(clk_in), .rd_data_in(dout), .rd_oe_in(oe),
    .search_done_in(done), .cpu_table_addr_out(addr),
    .start_probe_addr_out(start), .cpu_write_line_out(wr_ln),
    .lookup_select_out(sel), .cpu_data_bus_out(din));

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd(input logic [2:0] code, input logic [12:0] loc,
                    input logic [15:0] exp, input string name);
    logic [15:0] d;
    logic o;
    ats_cpu_model_i.access(code, 1'b0, loc, 16'h0000, d, o);
    chk(name, exp, d);
    chk("read enable", 16'h0001, {15'h0000, o});
  endtask

  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    chk("done", 16'h0001, {15'h0000, done});
    chk("steer", 16'h0000, {15'h0000, steer});
    chk("oe", 16'h0000, {15'h0000, oe});
    rd(SEL_OUTCOME, 13'h0000, OUTCOME_RST, "outcome");
  endtask

  task automatic test_store();
    logic [15:0] d;
    logic o;
    for (int i = 1; i < 8; i++) begin
      ats_cpu_model_i.store(13'(i), {3{16'(i)}});
    end
    rd(SEL_TBL_LO, 13'h0005, 16'h0005, "entry low");
    rd(SEL_TBL_MID, 13'h0005, 16'h0005, "entry mid");
    rd(SEL_TBL_HI, 13'h0005, 16'h0005, "entry high");
    rd(SEL_ARG_LO, 13'h0000, 16'h0007, "arg low");
    rd(SEL_ARG_MID, 13'h0000, 16'h0007, "arg mid");
    rd(SEL_ARG_HI, 13'h0000, 16'h0007, "arg high");
    ats_cpu_model_i.access(SEL_TBL_MID, 1'b1, 13'h0005, 16'hffff, d, o);
    chk("write enable", 16'h0000, {15'h0000, o});
    rd(SEL_TBL_MID, 13'h0005, 16'h0005, "entry mid kept");
  endtask

  task automatic run_search(input logic [47:0] arg, input logic [12:0] st,
                            input logic [15:0] exp);
    logic [15:0] d;
    logic o;
    int n;
    ats_cpu_model_i.search(arg, st);
    chk("search start", 16'h0000, {15'h0000, done});
    chk("first probe", {3'h0, st}, {3'h0, probe});
    n = 0;
    while (steer !== 1'b1 && n < 12) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("steer to probe", 16'h0001, {15'h0000, steer});
    // steering must follow done within one slow tick period
    chk("steer late", 16'h0001, {15'h0000, n <= STEER_TICK_CYC});
    ats_cpu_model_i.access(SEL_OUTCOME, 1'b0, 13'h0000, 16'h0000, d, o);
    chk("read while busy", 16'h0000, {15'h0000, o});
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("search end", 16'h0001, {15'h0000, done});
    n = 0;
    while (steer !== 1'b0 && n < 12) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("steer to cpu", 16'h0000, {15'h0000, steer});
    rd(SEL_OUTCOME, 13'h0000, exp, "outcome");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    test_reset();
    test_store();
    // match found after greater then less
    run_search(48'h0005_0005_0005, 13'h0004, 16'h800a);
    // no match, above the last odd leaf
    run_search(48'h0007_0007_0008, 13'h0004, 16'h000f);
    // below every entry, high slice decides
    run_search(48'h0000_ffff_ffff, 13'h0004, 16'h0002);
    // low slice decides, less then greater
    run_search(48'h0003_0003_0004, 13'h0004, 16'h0007);
    run_search(48'h0003_0003_0003, 13'h0003, 16'h8006);
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    wrap_up();
  end
endmodule
